// ===== rtl/sps_pkg.sv
// Package of constants and types for the sequential primitive set.
package sps_pkg;
   // Register bus address width in bits.
   localparam int unsigned SPS_ADR_W = 8;
   // Width of every programmable time field, in units of one enabled cycle.
   localparam int unsigned SPS_TIME_W = 15;
   // First clock generator word; generator i sits one word further per index.
   localparam logic [7:0] SPS_OFS_GEN0 = 8'h00;
   // Most generators that fit below the one-shot word.
   localparam int unsigned SPS_MAX_GEN = 4;
   // One-shot delay and duration word.
   localparam logic [7:0] SPS_OFS_OSHOT = 8'h10;
   // Read-only status word with the flop, carry, pulse and generator outputs.
   localparam logic [7:0] SPS_OFS_STATUS = 8'h14;
   // Field positions: low time or delay, high time or duration.
   localparam int unsigned SPS_LOW_LSB = 0;
   localparam int unsigned SPS_HIGH_LSB = 16;
   // Reset values of the programmable times.
   localparam logic [SPS_TIME_W-1:0] SPS_DEF_LOW = 15'h000a;
   localparam logic [SPS_TIME_W-1:0] SPS_DEF_HIGH = 15'h000a;
   localparam logic [SPS_TIME_W-1:0] SPS_DEF_DELAY = 15'h0001;
   localparam logic [SPS_TIME_W-1:0] SPS_DEF_WIDTH = 15'h000a;
   // Shortest time that a timer honours; zero is raised to it.
   localparam logic [SPS_TIME_W-1:0] SPS_TIME_MIN = 15'h0001;
   // Status word bit positions.
   localparam int unsigned SPS_ST_DQ = 0;
   localparam int unsigned SPS_ST_GEN = 8;
   // One-shot sequencer states.
   typedef enum logic [1:0] {
      SPS_OS_IDLE = 2'b00,
      SPS_OS_WAIT = 2'b01,
      SPS_OS_HIGH = 2'b10
   } sps_os_e;
endpackage : sps_pkg

// ===== rtl/sps_top.sv
// Sequential primitive set: flip-flops, register, counter, shifter, timers.
// What this block does
// - D flop captures on rise; set/clear override.
// - Enabled D flop captures only when enable high.
// - JK acts on fall: hold, clear, set, toggle.
// - JK set/clear override; both give both high.
// - JK output is defined whenever inputs determine it.
// - Register stores N bits; clear polarity selectable.
// - Counter counts up/down; enable is active low.
// - Carry low at terminal count for direction.
// - Counter clear zeroes count without element clock.
// - Low load input loads data, ignoring enable.
// - Enable high stops counting, not loading.
// - Counter width is 1 to 256 bits.
// - Shifter loads parallel data when select low.
// - Shifter moves serial in upward when select high.
// - Generator starts low, alternates low/high, default ten.
// - Generator times 1 to 32767, independent per generator.
// - Restart forces generators low, restarts low timer.
// - One-shot pulse after delay, lasting duration.
// - Retrigger extends pulse from latest trigger.
// - Edge elements use data from before the edge.
`timescale 1ns/100ps
module sps_top
#(
   parameter int unsigned REG_W        = 8,
   parameter int unsigned CNT_W        = 8,
   parameter int unsigned SHR_W        = 8,
   parameter int unsigned NUM_GEN      = 2,
   parameter logic        REG_CLR_HIGH = 1'b1
)
(
   input  wire logic                           clk_i,
   input  wire logic                           rst_i,
   input  wire logic                           ce_i,
   input  wire logic                           wb_cyc_i,
   input  wire logic                           wb_stb_i,
   input  wire logic                           wb_we_i,
   input  wire logic [sps_pkg::SPS_ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                     wb_sel_i,
   input  wire logic [31:0]                    wb_dat_i,
   output wire logic [31:0]                    wb_dat_o,
   output wire logic                           wb_ack_o,
   input  wire logic                           dff_clk_i,
   input  wire logic                           dff_d_i,
   input  wire logic                           dff_set_n_i,
   input  wire logic                           dff_clr_n_i,
   output wire logic                           dff_q_o,
   output wire logic                           dff_qn_o,
   input  wire logic                           dffe_clk_i,
   input  wire logic                           dffe_d_i,
   input  wire logic                           dffe_en_i,
   input  wire logic                           dffe_set_n_i,
   input  wire logic                           dffe_clr_n_i,
   output wire logic                           dffe_q_o,
   output wire logic                           dffe_qn_o,
   input  wire logic                           jk_clk_i,
   input  wire logic                           jk_j_i,
   input  wire logic                           jk_k_i,
   input  wire logic                           jk_set_n_i,
   input  wire logic                           jk_clr_n_i,
   output wire logic                           jk_q_o,
   output wire logic                           jk_qn_o,
   input  wire logic                           reg_clk_i,
   input  wire logic [REG_W-1:0]               reg_d_i,
   input  wire logic                           reg_clear_i,
   output wire logic [REG_W-1:0]               reg_q_o,
   input  wire logic                           cnt_clk_i,
   input  wire logic [CNT_W-1:0]               cnt_d_i,
   input  wire logic                           async_clear_i,
   input  wire logic                           direction_select_i,
   input  wire logic                           count_enable_n_i,
   input  wire logic                           parallel_load_n_i,
   output wire logic [CNT_W-1:0]               cnt_q_o,
   output wire logic                           carry_out_o,
   input  wire logic                           shr_clk_i,
   input  wire logic [SHR_W-1:0]               shr_d_i,
   input  wire logic                           shr_serial_i,
   input  wire logic                           shr_shift_i,
   output wire logic [SHR_W-1:0]               shr_q_o,
   input  wire logic                           sim_restart_i,
   output wire logic [NUM_GEN-1:0]             gen_clk_o,
   input  wire logic                           os_trig_i,
   output wire logic                           os_pulse_o
);
   import sps_pkg::*;

   localparam int unsigned TW = SPS_TIME_W;

   // Whole state of the block; every _p field is the previous input sample.
   typedef struct packed {
      logic                           ack;
      logic [31:0]                    rdat;
      logic [NUM_GEN-1:0][TW-1:0]     glow;
      logic [NUM_GEN-1:0][TW-1:0]     ghigh;
      logic [NUM_GEN-1:0][TW-1:0]     gcnt;
      logic [NUM_GEN-1:0]             gout;
      logic [TW-1:0]                  osdly;
      logic [TW-1:0]                  oswid;
      logic [TW-1:0]                  oscnt;
      sps_os_e                        osst;
      logic                           pulse;
      logic                           trig_p;
      logic                           dclk_p, dd_p, dq, dqn;
      logic                           eclk_p, ed_p, een_p, eq, eqn;
      logic                           jclk_p, jj_p, jk_p, jq, jqn;
      logic                           rclk_p;
      logic [REG_W-1:0]               rd_p, rq;
      logic                           cclk_p, cup_p, cenn_p, cldn_p, carry;
      logic [CNT_W-1:0]               cd_p, cq;
      logic                           sclk_p, ssi_p, ssh_p;
      logic [SHR_W-1:0]               sd_p, sq;
   } sps_state_s;

   sps_state_s s_q;        // Registered state.
   sps_state_s s_d;        // Next state.
   logic       d_rise;     // Element clock edges seen this cycle.
   logic       e_rise;
   logic       j_fall;
   logic       r_rise;
   logic       c_rise;
   logic       s_rise;
   logic       os_rise;
   logic       wb_req;     // A new bus request, not yet answered.

   // Raises a zero time to the shortest legal one.
   function automatic logic [TW-1:0] sps_clamp(input logic [TW-1:0] t);
      return (t < SPS_TIME_MIN) ? SPS_TIME_MIN : t;
   endfunction : sps_clamp

   // True when a byte address lands on the given word.
   function automatic logic sps_hit(input logic [7:0] a, input logic [7:0] ofs);
      return {a[7:2], 2'b00} == ofs;
   endfunction : sps_hit

   // Merges write data into a word along the byte enables.
   function automatic logic [31:0] sps_merge(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[b*8 +: 8] = dat[b*8 +: 8];
         end
      end
      return r;
   endfunction : sps_merge

   // Packs a pair of times into one register word.
   function automatic logic [31:0] sps_pair(input logic [TW-1:0] lo,
                                           input logic [TW-1:0] hi);
      return {1'b0, hi, 1'b0, lo};
   endfunction : sps_pair

   // Edges compare the live level with the last sample, so data seen with
   // an edge is always the value from before it.
   assign d_rise  = dff_clk_i & ~s_q.dclk_p;
   assign e_rise  = dffe_clk_i & ~s_q.eclk_p;
   assign j_fall  = ~jk_clk_i & s_q.jclk_p;
   assign r_rise  = reg_clk_i & ~s_q.rclk_p;
   assign c_rise  = cnt_clk_i & ~s_q.cclk_p;
   assign s_rise  = shr_clk_i & ~s_q.sclk_p;
   assign os_rise = os_trig_i & ~s_q.trig_p;
   assign wb_req  = wb_cyc_i & wb_stb_i & ~s_q.ack;

   // Next-state logic for every element and the bus slave.
   always_comb
   begin
      logic [31:0] wv;
      wv  = 32'h0000_0000;
      s_d = s_q;
      // Bus slave: one ack per request, registered read data.
      s_d.ack  = wb_req;
      s_d.rdat = 32'h0000_0000;
      if (wb_req && sps_hit(wb_adr_i, SPS_OFS_OSHOT))
      begin
         s_d.rdat = sps_pair(s_q.osdly, s_q.oswid);
         wv       = sps_merge(s_d.rdat, wb_dat_i, wb_sel_i);
         if (wb_we_i)
         begin
            s_d.osdly = wv[SPS_LOW_LSB +: TW];
            s_d.oswid = wv[SPS_HIGH_LSB +: TW];
         end
      end
      else if (wb_req && sps_hit(wb_adr_i, SPS_OFS_STATUS))
      begin
         // Status is read-only; writes are acknowledged and dropped.
         s_d.rdat = 32'({s_q.gout, s_q.pulse, s_q.carry, s_q.jqn, s_q.jq,
                         s_q.eqn, s_q.eq, s_q.dqn, s_q.dq}) << SPS_ST_DQ;
      end
      for (int i = 0; i < NUM_GEN; i++)
      begin
         if (wb_req && sps_hit(wb_adr_i, SPS_OFS_GEN0 + 8'(i * 4)))
         begin
            s_d.rdat = sps_pair(s_q.glow[i], s_q.ghigh[i]);
            wv       = sps_merge(s_d.rdat, wb_dat_i, wb_sel_i);
            if (wb_we_i)
            begin
               s_d.glow[i]  = wv[SPS_LOW_LSB +: TW];
               s_d.ghigh[i] = wv[SPS_HIGH_LSB +: TW];
            end
         end
      end

      // Plain D flop: set low gives Q high, clear low gives Q/ high.
      if (!dff_set_n_i || !dff_clr_n_i)
      begin
         s_d.dq  = ~dff_set_n_i;
         s_d.dqn = ~dff_clr_n_i;
      end
      else if (d_rise)
      begin
         s_d.dq  = s_q.dd_p;
         s_d.dqn = ~s_q.dd_p;
      end

      // Enabled D flop: the enable is judged at the edge, like the data.
      if (!dffe_set_n_i || !dffe_clr_n_i)
      begin
         s_d.eq  = ~dffe_set_n_i;
         s_d.eqn = ~dffe_clr_n_i;
      end
      else if (e_rise && s_q.een_p)
      begin
         s_d.eq  = s_q.ed_p;
         s_d.eqn = ~s_q.ed_p;
      end

      // JK flop on the falling edge. Leaving the both-high override
      // resumes from Q high, a defined stand-in for the unknown state.
      if (!jk_set_n_i || !jk_clr_n_i)
      begin
         s_d.jq  = ~jk_set_n_i;
         s_d.jqn = ~jk_clr_n_i;
      end
      else if (j_fall)
      begin
         // Characteristic equation: an unknown J or K still gives a known
         // result wherever both outcomes agree.
         s_d.jq  = (s_q.jj_p & ~s_q.jq) | (~s_q.jk_p & s_q.jq);
         s_d.jqn = ~s_d.jq;
      end

      // Register: clear acts every cycle, independent of its own clock.
      if (reg_clear_i == REG_CLR_HIGH)
      begin
         s_d.rq = '0;
      end
      else if (r_rise)
      begin
         s_d.rq = s_q.rd_p;
      end

      // Counter: clear, then load, then count when enabled.
      if (async_clear_i)
      begin
         s_d.cq = '0;
      end
      else if (c_rise && !s_q.cldn_p)
      begin
         s_d.cq = s_q.cd_p;
      end
      else if (c_rise && !s_q.cenn_p)
      begin
         // Natural wrap of a CNT_W-bit sum.
         s_d.cq = s_q.cup_p ? s_q.cq + 1'b1 : s_q.cq - 1'b1;
      end
      // Carry low at terminal count; a later stage may use it as its
      // active-low enable on the shared clock.
      s_d.carry = ~((direction_select_i && (&s_d.cq)) ||
                    (!direction_select_i && (s_d.cq == '0)));

      // Shifter: load when select low, else shift toward the top.
      if (s_rise && !s_q.ssh_p)
      begin
         s_d.sq = s_q.sd_p;
      end
      else if (s_rise)
      begin
         s_d.sq = (s_q.sq << 1) | SHR_W'(s_q.ssi_p);
      end

      // Generators count enabled cycles; zero times act as one.
      for (int i = 0; i < NUM_GEN; i++)
      begin
         if (sim_restart_i)
         begin
            s_d.gout[i] = 1'b0;
            s_d.gcnt[i] = sps_clamp(s_q.glow[i]);
         end
         else if (s_q.gcnt[i] <= SPS_TIME_MIN)
         begin
            s_d.gout[i] = ~s_q.gout[i];
            s_d.gcnt[i] = s_q.gout[i] ? sps_clamp(s_q.glow[i])
                                      : sps_clamp(s_q.ghigh[i]);
         end
         else
         begin
            s_d.gcnt[i] = s_q.gcnt[i] - 1'b1;
         end
      end

      // One-shot: a trigger always restarts the delay, pulse untouched.
      if (os_rise)
      begin
         s_d.osst  = SPS_OS_WAIT;
         s_d.oscnt = sps_clamp(s_q.osdly);
      end
      else
      begin
         case (s_q.osst)
            SPS_OS_WAIT:
            begin
               if (s_q.oscnt <= SPS_TIME_MIN)
               begin
                  s_d.pulse = 1'b1;
                  s_d.osst  = SPS_OS_HIGH;
                  s_d.oscnt = sps_clamp(s_q.oswid);
               end
               else
               begin
                  s_d.oscnt = s_q.oscnt - 1'b1;
               end
            end
            SPS_OS_HIGH:
            begin
               if (s_q.oscnt <= SPS_TIME_MIN)
               begin
                  s_d.pulse = 1'b0;
                  s_d.osst  = SPS_OS_IDLE;
               end
               else
               begin
                  s_d.oscnt = s_q.oscnt - 1'b1;
               end
            end
            default:
            begin
               s_d.pulse = 1'b0;
               s_d.osst  = SPS_OS_IDLE;
            end
         endcase
      end

      // Input history for edge detection and old-value sampling.
      s_d.dclk_p = dff_clk_i;
      s_d.dd_p   = dff_d_i;
      s_d.eclk_p = dffe_clk_i;
      s_d.ed_p   = dffe_d_i;
      s_d.een_p  = dffe_en_i;
      s_d.jclk_p = jk_clk_i;
      s_d.jj_p   = jk_j_i;
      s_d.jk_p   = jk_k_i;
      s_d.rclk_p = reg_clk_i;
      s_d.rd_p   = reg_d_i;
      s_d.cclk_p = cnt_clk_i;
      s_d.cd_p   = cnt_d_i;
      s_d.cup_p  = direction_select_i;
      s_d.cenn_p = count_enable_n_i;
      s_d.cldn_p = parallel_load_n_i;
      s_d.sclk_p = shr_clk_i;
      s_d.sd_p   = shr_d_i;
      s_d.ssi_p  = shr_serial_i;
      s_d.ssh_p  = shr_shift_i;
      s_d.trig_p = os_trig_i;

      // Reset values; defaults give the documented times.
      if (rst_i)
      begin
         s_d       = '0;
         s_d.dqn   = 1'b1;
         s_d.eqn   = 1'b1;
         s_d.jqn   = 1'b1;
         s_d.carry = 1'b1;
         s_d.osst  = SPS_OS_IDLE;
         s_d.osdly = SPS_DEF_DELAY;
         s_d.oswid = SPS_DEF_WIDTH;
         for (int i = 0; i < NUM_GEN; i++)
         begin
            s_d.glow[i]  = SPS_DEF_LOW;
            s_d.ghigh[i] = SPS_DEF_HIGH;
            s_d.gcnt[i]  = SPS_DEF_LOW;
         end
      end
   end

   // State register; a low clock enable freezes everything but reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i || ce_i)
      begin
         s_q <= s_d;
      end
   end

   // All outputs come straight from the state register.
   assign wb_dat_o    = s_q.rdat;
   assign wb_ack_o    = s_q.ack;
   assign dff_q_o     = s_q.dq;
   assign dff_qn_o    = s_q.dqn;
   assign dffe_q_o    = s_q.eq;
   assign dffe_qn_o   = s_q.eqn;
   assign jk_q_o      = s_q.jq;
   assign jk_qn_o     = s_q.jqn;
   assign reg_q_o     = s_q.rq;
   assign cnt_q_o     = s_q.cq;
   assign carry_out_o = s_q.carry;
   assign shr_q_o     = s_q.sq;
   assign gen_clk_o   = s_q.gout;
   assign os_pulse_o  = s_q.pulse;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Checks on the element behaviour.
   dff_both_high_a: assert property (ce_i && !dff_set_n_i && !dff_clr_n_i
      |=> dff_q_o && dff_qn_o) else $error("dff override");
   dffe_hold_a: assert property (ce_i && e_rise && !s_q.een_p && dffe_set_n_i
      && dffe_clr_n_i |=> $stable(dffe_q_o)) else $error("dffe hold");
   jk_toggle_a: assert property (ce_i && j_fall && s_q.jj_p && s_q.jk_p &&
      jk_set_n_i && jk_clr_n_i |=> jk_q_o != $past(jk_q_o) && jk_qn_o == !jk_q_o)
      else $error("jk toggle");
   jk_set_a: assert property (ce_i && !jk_set_n_i && jk_clr_n_i
      |=> jk_q_o && !jk_qn_o) else $error("jk set");
   cnt_clear_a: assert property (ce_i && async_clear_i |=> cnt_q_o == '0)
      else $error("counter clear");
   cnt_load_a: assert property (ce_i && c_rise && !s_q.cldn_p && !async_clear_i
      |=> cnt_q_o == $past(s_q.cd_p)) else $error("counter load");
   cnt_carry_a: assert property (ce_i |=> carry_out_o == !(($past(direction_select_i)
      && &cnt_q_o) || (!$past(direction_select_i) && cnt_q_o == '0)))
      else $error("carry value");
   shr_shift_a: assert property (ce_i && s_rise && s_q.ssh_p |=> shr_q_o ==
      (($past(shr_q_o) << 1) | SHR_W'($past(s_q.ssi_p)))) else $error("shift");
   gen_restart_a: assert property (ce_i && sim_restart_i |=> gen_clk_o == '0)
      else $error("generator restart");
   os_start_a: assert property (ce_i && !os_rise && s_q.osst == SPS_OS_WAIT &&
      s_q.oscnt <= SPS_TIME_MIN |=> os_pulse_o) else $error("pulse start");
   os_retrig_a: assert property (ce_i && os_rise && os_pulse_o |=> os_pulse_o)
      else $error("retrigger drop");
   wb_ack_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack length");

   carry_low_c: cover property (ce_i ##1 !carry_out_o);
   pulse_c: cover property (os_rise ##[1:40] os_pulse_o);
   gen_rise_c: cover property (!gen_clk_o[0] ##1 gen_clk_o[0]);
   wb_write_c: cover property (wb_req && wb_we_i ##1 wb_ack_o);
endmodule : sps_top

// ===== verification/sps_cascade_model.sv
// Partner model: a more significant counter stage cascaded on carry_out.
`timescale 1ns/100ps
module sps_cascade_model
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       cnt_clk_i,
   input  wire logic       carry_out_i,
   output logic [3:0]      upper_o
);
   // Previous samples, so that an edge acts on values from before it.
   logic ck_q;
   logic co_q;
   // The upper stage shares the lower stage clock and is enabled by a low carry.
   always_ff @(posedge clk_i)
   begin
      ck_q <= cnt_clk_i;
      co_q <= carry_out_i;
      if (rst_i)
      begin
         upper_o <= 4'h0;
      end
      else if (cnt_clk_i && !ck_q && !co_q)
      begin
         upper_o <= upper_o + 4'h1;
      end
   end
endmodule : sps_cascade_model

// ===== verification/sequential_primitive_set_tb.sv
// Self-checking bench for the sequential primitive set.
`timescale 1ns/100ps
module sequential_primitive_set_tb;
   import sps_pkg::*;
   // Bus master signals, changed only right after rising edges.
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat;
   // Element clocks: dff, dffe, jk, register, counter, shifter.
   logic [5:0]  ek = 6'h00;
   logic        d = 1'b0, en = 1'b0, set_n = 1'b1, clr_n = 1'b1;
   logic        j = 1'b0, k = 1'b0, js_n = 1'b1, jc_n = 1'b1;
   logic        rclr = 1'b0, ser = 1'b0, sh = 1'b0, aclr = 1'b0, ce = 1'b1;
   logic        dir = 1'b1, cen_n = 1'b1, ld_n = 1'b1, restart = 1'b0, trig = 1'b0;
   logic [7:0]  rd = 8'h00, sd = 8'h00;
   logic [3:0]  cd = 4'h0, sel = 4'hf;
   wire  logic [31:0] dat_o;
   wire  logic        ack, dq, dqn, eq, eqn, jq, jqn, co, pulse;
   wire  logic [7:0]  rq, sq;
   wire  logic [3:0]  cq, up;
   wire  logic [1:0]  gen;
   int          n_mismatch = 0, checks_done = 0;
   // A small counter keeps carry and wrap cases a few edges apart.
   always #5 clk_i = ~clk_i;
   sps_top #(.CNT_W(4)) sps_top_inst (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .dff_clk_i(ek[0]), .dff_d_i(d), .dff_set_n_i(set_n), .dff_clr_n_i(clr_n),
      .dff_q_o(dq), .dff_qn_o(dqn), .dffe_clk_i(ek[1]), .dffe_d_i(d), .dffe_en_i(en),
      .dffe_set_n_i(set_n), .dffe_clr_n_i(clr_n), .dffe_q_o(eq), .dffe_qn_o(eqn),
      .jk_clk_i(ek[2]), .jk_j_i(j), .jk_k_i(k), .jk_set_n_i(js_n), .jk_clr_n_i(jc_n),
      .jk_q_o(jq), .jk_qn_o(jqn), .reg_clk_i(ek[3]), .reg_d_i(rd), .reg_clear_i(rclr),
      .reg_q_o(rq), .cnt_clk_i(ek[4]), .cnt_d_i(cd), .async_clear_i(aclr),
      .direction_select_i(dir), .count_enable_n_i(cen_n), .parallel_load_n_i(ld_n),
      .cnt_q_o(cq), .carry_out_o(co), .shr_clk_i(ek[5]), .shr_d_i(sd), .shr_serial_i(ser),
      .shr_shift_i(sh), .shr_q_o(sq), .sim_restart_i(restart), .gen_clk_o(gen),
      .os_trig_i(trig), .os_pulse_o(pulse));
   sps_cascade_model sps_cascade_model_inst (.clk_i(clk_i), .rst_i(rst_i), .cnt_clk_i(ek[4]),
      .carry_out_i(co), .upper_o(up));
   // Compares one value and reports a mismatch at once.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Prints the verdict and ends the run.
   task automatic finish_test;
      if (n_mismatch == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   // A wait that runs out counts as a mismatch and ends the run.
   task automatic expire;
      chk("timeout", 32'h1, 32'h0);
      finish_test();
   endtask : expire
   // One classic Wishbone cycle, held until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic [3:0] s = 4'hf);
      int i;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, v, s};
      i = 0;
      do
      begin
         @(posedge clk_i);
         i++;
      end
      while (ack !== 1'b1 && i < 20);
      if (i >= 20)
         expire();
      rdat = dat_o;
      {cyc, stb} <= 2'b00;
   endtask : wb
   // Pulses the masked element clocks; each level lasts two system cycles.
   task automatic tick(input logic [5:0] m);
      @(posedge clk_i);
      ek <= m;
      repeat (2) @(posedge clk_i);
      ek <= 6'h00;
      repeat (2) @(posedge clk_i);
   endtask : tick
   // Measures one high span of a timer output and, for a generator only, the following low span.
   task automatic span(input int b, output int h, output int l);
      int i;
      {i, h, l} = '0;
      while ((b < 2 ? gen[b] : pulse) !== 1'b1 && i < 200)
      begin
         @(negedge clk_i);
         i++;
      end
      while ((b < 2 ? gen[b] : pulse) === 1'b1 && h < 200)
      begin
         @(negedge clk_i);
         h++;
      end
      while (b < 2 && gen[b] !== 1'b1 && l < 200)
      begin
         @(negedge clk_i);
         l++;
      end
      if (i + h + l >= 200)
         expire();
   endtask : span
   // Reset values, read-only status, unmapped place and field widths.
   task automatic t_bus;
      wb(1'b1, SPS_OFS_STATUS, 32'hffff_ffff);
      wb(1'b0, SPS_OFS_STATUS, 32'h0);
      chk("status", 32'h0000_006a, rdat);
      wb(1'b0, 8'h1c, 32'h0);
      chk("unmapped", 32'h0, rdat);
      wb(1'b0, SPS_OFS_GEN0, 32'h0);
      chk("gen0 times", 32'h000a_000a, rdat);
      wb(1'b0, SPS_OFS_OSHOT, 32'h0);
      chk("oneshot times", 32'h000a_0001, rdat);
      wb(1'b1, SPS_OFS_GEN0 + 8'h04, 32'hffff_ffff);
      wb(1'b0, SPS_OFS_GEN0 + 8'h04, 32'h0);
      chk("gen1 max", 32'h7fff_7fff, rdat);
      wb(1'b1, SPS_OFS_GEN0 + 8'h04, 32'h0000_000a, 4'h3);
      wb(1'b0, SPS_OFS_GEN0 + 8'h04, 32'h0);
      chk("gen1 low bytes", 32'h7fff_000a, rdat);
      wb(1'b1, SPS_OFS_GEN0 + 8'h04, 32'h000a_000a);
   endtask : t_bus
   // D flops: capture, enable, old data at the edge, set and clear low together.
   task automatic t_flops;
      {d, en} <= 2'b10;
      tick(6'h03);
      chk("dff", 32'h2, {dq, dqn});
      chk("dffe hold", 32'h1, {eq, eqn});
      en <= 1'b1;
      tick(6'h02);
      chk("dffe", 32'h2, {eq, eqn});
      @(posedge clk_i);
      {ek, d} <= {6'h01, 1'b0};
      tick(6'h00);
      chk("dff old data", 32'h2, {dq, dqn});
      {set_n, clr_n} <= 2'b00;
      repeat (2) @(posedge clk_i);
      chk("dff both", 32'h3, {dq, dqn});
      {set_n, clr_n} <= 2'b11;
   endtask : t_flops
   // JK: every input pair on falling edges, then every override.
   task automatic t_jk;
      logic [11:0] jkv = 12'b00_10_00_11_11_01;
      logic [5:0]  qv = 6'b011010;
      logic [5:0]  ov = 6'b10_01_00;
      logic [5:0]  oq = 6'b01_10_11;
      for (int i = 0; i < 6; i++)
      begin
         {j, k} <= jkv[11-2*i -: 2];
         tick(6'h04);
         chk("jk", {qv[5-i], ~qv[5-i]}, {jq, jqn});
      end
      for (int i = 0; i < 3; i++)
      begin
         {js_n, jc_n} <= ov[5-2*i -: 2];
         repeat (2) @(posedge clk_i);
         chk("jk override", oq[5-2*i -: 2], {jq, jqn});
      end
      {js_n, jc_n} <= 2'b11;
   endtask : t_jk
   // Register load and clear; shifter load, then shift losing the top bit.
   task automatic t_regs;
      {rd, sd, sh} <= {8'ha5, 8'h81, 1'b0};
      tick(6'h28);
      chk("reg", 32'ha5, rq);
      chk("shr load", 32'h81, sq);
      {sh, ser} <= 2'b11;
      tick(6'h20);
      chk("shr shift", 32'h03, sq);
      rclr <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("reg clear", 32'h0, rq);
      {rclr, ce} <= 2'b00;
      tick(6'h08);
      chk("reg frozen", 32'h0, rq);
      ce <= 1'b1;
   endtask : t_regs
   // Counter: load while disabled, carry, wrap both ways, cascade, clear.
   task automatic t_count;
      {cd, ld_n, cen_n} <= {4'he, 1'b0, 1'b1};
      tick(6'h10);
      chk("cnt load", 32'he, cq);
      ld_n <= 1'b1;
      tick(6'h10);
      chk("cnt stopped", 32'he, cq);
      cen_n <= 1'b0;
      tick(6'h10);
      chk("cnt up", 32'h0f, {co, cq});
      tick(6'h10);
      chk("cnt wrap", 32'h10, {co, cq});
      chk("upper stage", 32'h1, up);
      dir <= 1'b0;
      tick(6'h10);
      chk("cnt down", 32'h1f, {co, cq});
      aclr <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("cnt clear", 32'h0, cq);
      aclr <= 1'b0;
   endtask : t_count
   // Generators: restart, then programmed and default spans.
   task automatic t_gen;
      int h;
      int l;
      wb(1'b1, SPS_OFS_GEN0, 32'h0002_0003);
      @(posedge clk_i);
      restart <= 1'b1;
      @(posedge clk_i);
      restart <= 1'b0;
      @(posedge clk_i);
      chk("gen restart", 32'h0, gen);
      span(0, h, l);
      chk("gen0 spans", {16'd2, 16'd3}, {h[15:0], l[15:0]});
      span(1, h, l);
      chk("gen1 spans", {16'd10, 16'd10}, {h[15:0], l[15:0]});
   endtask : t_gen
   // Raises the one-shot trigger for one cycle.
   task automatic pull;
      @(posedge clk_i);
      trig <= 1'b1;
      @(posedge clk_i);
      trig <= 1'b0;
   endtask : pull
   // One-shot: plain pulse, then a retrigger while high.
   task automatic t_oshot;
      int h;
      int l;
      wb(1'b1, SPS_OFS_OSHOT, 32'h0004_0002);
      pull();
      span(2, h, l);
      chk("pulse len", 32'd4, h);
      pull();
      span(2, h, l);
      chk("pulse again", 32'd4, h);
      pull();
      l = 0;
      while (pulse !== 1'b1 && l < 50)
      begin
         @(negedge clk_i);
         l++;
      end
      // Retrigger while high: pulse holds through delay 2 plus duration 4.
      pull();
      h = 0;
      while (pulse === 1'b1 && h < 50)
      begin
         @(negedge clk_i);
         h++;
      end
      if (l + h >= 50)
         expire();
      chk("pulse extended", 32'd7, h);
   endtask : t_oshot
   // Main sequence: reset for ten cycles, then every scenario.
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_bus();
      t_flops();
      t_jk();
      t_regs();
      t_count();
      t_gen();
      t_oshot();
      finish_test();
   end
endmodule : sequential_primitive_set_tb
